// File: include/tcp_pkg.sv
package tcp_pkg;
  // Register map, byte offsets on the plain register port
  localparam logic [7:0] TCP_OFS_TIMER_CONTROL_B = 8'h2F;
  localparam logic [7:0] TCP_OFS_PLL_CONTROL_STATUS = 8'h29;
  localparam int TCP_ADDR_W = 8;
  localparam int TCP_DATA_W = 8;
  // Field positions in timer_control_b
  localparam int TCP_TCB_RSVD_BIT = 7;
  localparam int TCP_TCB_RESTART_BIT = 6;
  localparam int TCP_TCB_DTPS_HI = 5;
  localparam int TCP_TCB_DTPS_LO = 4;
  localparam int TCP_TCB_CS_HI = 3;
  localparam int TCP_TCB_CS_LO = 0;
  // Field positions in pll_control_status
  localparam int TCP_PCS_HALF_BIT = 7;
  localparam int TCP_PCS_ASYNC_BIT = 2;
  localparam int TCP_PCS_PLL_ON_BIT = 1;
  localparam int TCP_PCS_LOCK_BIT = 0;
  // Values after reset
  localparam logic [7:0] TCP_TCB_RESET = 8'h00;
  localparam logic TCP_HALF_RESET = 1'b0;
  localparam logic TCP_ASYNC_RESET = 1'b0;
  localparam logic TCP_PLL_ON_RESET = 1'b0;
  // Prescaler
  localparam int TCP_SEL_W = 4;
  localparam int TCP_DIV_W = 14;
  localparam logic [3:0] TCP_SEL_STOP = 4'h0;
  localparam logic [3:0] TCP_SEL_DIV1 = 4'h1;
  // Software lock-in settle time, kept for reference
  localparam int TCP_LOCK_SETTLE_US = 100;
  localparam int TCP_CLK_MHZ = 125;
  localparam int TCP_LOCK_SETTLE_CYC = TCP_LOCK_SETTLE_US * TCP_CLK_MHZ;
  typedef enum logic [0:0] {TCP_SRC_SYS, TCP_SRC_FAST} tcp_src_t;
endpackage

// File: include/tcp_div_if.sv
`timescale 1ns/10ps
interface tcp_div_if;
  logic src_tick;
  logic restart;
  logic [3:0] sel;
  logic tick;
  modport ctrl (output src_tick, output restart, output sel, input tick);
  modport div (input src_tick, input restart, input sel, output tick);
endinterface

// File: verilog/tcp_divider.sv
`timescale 1ns/10ps
module tcp_divider (
  input wire logic clk_in,
  input wire logic rst_n_in,
  tcp_div_if.div bus
);
  import tcp_pkg::*;

  logic [TCP_DIV_W-1:0] cnt_ff;
  logic [TCP_DIV_W-1:0] nxt_cnt;
  logic [15:0] tap;

  // Divider counter advances on each source tick, restart clears it
  assign nxt_cnt = bus.restart ? '0 :
                   bus.src_tick ? cnt_ff + 14'h0001 : cnt_ff;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Tap k from 1 up fires when the low k-1 counter bits are all ones
  assign tap[0] = 1'b0; // Stop code
  assign tap[1] = bus.src_tick; // Undivided source
  genvar k;
  generate
    for (k = 2; k < 16; k++) begin : g_tap
      assign tap[k] = bus.src_tick && !bus.restart && (&cnt_ff[k-2:0]);
    end
  endgenerate

  assign bus.tick = tap[bus.sel];
endmodule

// File: verilog/tcp_top.sv
// Notes on behaviour
// - Timer source is system clock when async select is 0, else fast clock.
// - Fast peripheral clock runs full rate, or half rate in low-speed mode.
// - Half-speed bit 7 resets to zero; writing one halves the fast clock.
// - Status bits 6 to 3 are read-only and read zero.
// - Async select accepts one only while PLL is on by bit or fuses.
// - PLL enable starts the PLL; reads one when PLL is system clock.
// - Read-only lock flag at bit 0; software ignores it first 100 us.
// - Writing one to bit 6 restarts the divider, self-clears, reads zero.
// - Select code 0 stops, 1 passes clock, each step doubles to 16384.
`timescale 1ns/10ps
module tcp_top (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [tcp_pkg::TCP_ADDR_W-1:0] addr_in,
  input wire logic [tcp_pkg::TCP_DATA_W-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic fast_tick_in,
  input wire logic pll_locked_in,
  input wire logic fuse_pll_mode_in,
  output logic [tcp_pkg::TCP_DATA_W-1:0] rd_data_out,
  output logic timer_tick_out,
  output logic pll_on_out,
  output logic async_mode_out,
  output logic half_speed_out,
  output logic divider_restart_out
);
  import tcp_pkg::*;

  // Reset release through two flops
  logic rst_s1_ff;
  logic rst_s2_ff;
  logic rst_n;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  assign rst_n = rst_s2_ff;

  // Lock and fuse pins pass two flops before any logic reads them
  logic lock_s1_ff;
  logic lock_s2_ff;
  logic fuse_s1_ff;
  logic fuse_s2_ff;

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      lock_s1_ff <= 1'b0;
      lock_s2_ff <= 1'b0;
      fuse_s1_ff <= 1'b0;
      fuse_s2_ff <= 1'b0;
    end else begin
      lock_s1_ff <= pll_locked_in;
      lock_s2_ff <= lock_s1_ff;
      fuse_s1_ff <= fuse_pll_mode_in;
      fuse_s2_ff <= fuse_s1_ff;
    end
  end

  // Register state
  logic tcb_rsvd_ff;
  logic [1:0] tcb_dtps_ff;
  logic [3:0] sel_ff;
  logic half_ff;
  logic async_ff;
  logic pll_on_ff;
  logic restart_ff;
  logic half_phase_ff;
  logic tick_ff;
  logic [7:0] rd_data_ff;

  logic tcb_wr;
  logic pcs_wr;
  logic pll_running;
  logic nxt_async;
  logic nxt_restart;
  logic nxt_half_phase;
  logic fast_tick_gated;
  logic src_tick;
  logic [7:0] tcb_view;
  logic [7:0] pcs_view;
  logic [7:0] nxt_rd_data;
  logic tcb_hit;
  logic pcs_hit;

  // Register select, shared by the write and the read decode
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  // Address decode
  assign tcb_hit = reg_hit(addr_in, TCP_OFS_TIMER_CONTROL_B);
  assign pcs_hit = reg_hit(addr_in, TCP_OFS_PLL_CONTROL_STATUS);
  assign tcb_wr = wr_en_in && tcb_hit;
  assign pcs_wr = wr_en_in && pcs_hit;

  // PLL counts as running when software or the fuses turn it on
  assign pll_running = pll_on_ff || fuse_s2_ff;

  // Async select takes a one only while the PLL runs
  assign nxt_async = pcs_wr ?
                     (wr_data_in[TCP_PCS_ASYNC_BIT] && pll_running) :
                     async_ff;

  // Restart pulse from a write of one; a zero write does nothing
  assign nxt_restart = tcb_wr && wr_data_in[TCP_TCB_RESTART_BIT];

  // Half-speed mode drops every other fast tick
  assign nxt_half_phase = fast_tick_in ? ~half_phase_ff : half_phase_ff;
  assign fast_tick_gated = fast_tick_in && (!half_ff || half_phase_ff);

  // Source select: system clock ticks every cycle
  assign src_tick = async_ff ? fast_tick_gated : 1'b1;

  // Read views
  assign tcb_view = {tcb_rsvd_ff, 1'b0, tcb_dtps_ff, sel_ff};
  assign pcs_view = {half_ff, 4'h0, async_ff, pll_running, lock_s2_ff};

  // Read data mux, unmapped addresses read zero
  assign nxt_rd_data = !rd_en_in ? 8'h00 :
                       tcb_hit ? tcb_view :
                       pcs_hit ? pcs_view : 8'h00;

  // Timer control register
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tcb_rsvd_ff <= TCP_TCB_RESET[TCP_TCB_RSVD_BIT];
      tcb_dtps_ff <= TCP_TCB_RESET[TCP_TCB_DTPS_HI:TCP_TCB_DTPS_LO];
      sel_ff <= TCP_TCB_RESET[TCP_TCB_CS_HI:TCP_TCB_CS_LO];
    end else if (tcb_wr) begin
      tcb_rsvd_ff <= wr_data_in[TCP_TCB_RSVD_BIT];
      tcb_dtps_ff <= wr_data_in[TCP_TCB_DTPS_HI:TCP_TCB_DTPS_LO];
      sel_ff <= wr_data_in[TCP_TCB_CS_HI:TCP_TCB_CS_LO];
    end
  end

  // PLL control register
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      half_ff <= TCP_HALF_RESET;
      pll_on_ff <= TCP_PLL_ON_RESET;
    end else if (pcs_wr) begin
      half_ff <= wr_data_in[TCP_PCS_HALF_BIT];
      pll_on_ff <= wr_data_in[TCP_PCS_PLL_ON_BIT];
    end
  end

  // Async select and self-clearing restart
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      async_ff <= TCP_ASYNC_RESET;
      restart_ff <= 1'b0;
    end else begin
      async_ff <= nxt_async;
      restart_ff <= nxt_restart;
    end
  end

  // Half-speed phase follows the fast ticks
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      half_phase_ff <= 1'b0;
    end else begin
      half_phase_ff <= nxt_half_phase;
    end
  end

  // Divider
  tcp_div_if div_bus ();

  assign div_bus.src_tick = src_tick;
  assign div_bus.restart = restart_ff;
  assign div_bus.sel = sel_ff;

  tcp_divider u_div (
    .clk_in (ref_clk_in),
    .rst_n_in (rst_n),
    .bus (div_bus.div)
  );

  // Registered outputs
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tick_ff <= 1'b0;
      rd_data_ff <= 8'h00;
    end else begin
      tick_ff <= div_bus.tick;
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign timer_tick_out = tick_ff;
  assign rd_data_out = rd_data_ff;
  assign pll_on_out = pll_on_ff;
  assign async_mode_out = async_ff;
  assign half_speed_out = half_ff;
  assign divider_restart_out = restart_ff;
endmodule

// File: tb/tcp_top_asserts.sv
`timescale 1ns/10ps
module tcp_top_asserts (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic fast_tick_in,
  input wire logic pll_locked_in,
  input wire logic fuse_pll_mode_in,
  input wire logic [7:0] rd_data_out,
  input wire logic timer_tick_out,
  input wire logic pll_on_out,
  input wire logic async_mode_out,
  input wire logic half_speed_out,
  input wire logic divider_restart_out
);
  import tcp_pkg::*;
  logic [3:0] sel_ff;
  // Register port decode
  wire rd_pcs = rd_en_in && addr_in == TCP_OFS_PLL_CONTROL_STATUS;
  wire wr_pcs = wr_en_in && addr_in == TCP_OFS_PLL_CONTROL_STATUS;
  wire wr_tcb = wr_en_in && addr_in == TCP_OFS_TIMER_CONTROL_B;
  wire rd_tcb = rd_en_in && addr_in == TCP_OFS_TIMER_CONTROL_B;
  wire restart_req = wr_tcb && wr_data_in[6];
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Copy of the select field as last written
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel_ff <= 4'h0;
    end else if (wr_tcb) begin
      sel_ff <= wr_data_in[3:0];
    end
  end
  a_status_reserved: assert property (
    rd_pcs |=> rd_data_out[6:3] == 4'h0) else $error("status reserved bits set");
  a_pll_on_read: assert property (
    rd_pcs && pll_on_out |=> rd_data_out[1]) else $error("pll on reads zero");
  a_half_store: assert property (
    wr_pcs |=> half_speed_out == $past(wr_data_in[7])) else $error("half speed not stored");
  a_async_gated: assert property (
    $rose(async_mode_out) |-> $past(pll_on_out) || $past(fuse_pll_mode_in, 3))
    else $error("async set with pll off");
  a_restart_pulse: assert property (
    restart_req |=> divider_restart_out) else $error("no restart pulse");
  a_restart_once: assert property (
    divider_restart_out |-> $past(restart_req)) else $error("restart without request");
  a_restart_rd_zero: assert property (
    rd_tcb |=> !rd_data_out[6]) else $error("restart bit reads one");
  a_lock_view: assert property (
    rd_pcs |=> rd_data_out[0] == $past(pll_locked_in, 3)) else $error("lock flag mismatch");
  a_stop_no_tick: assert property (
    $past(sel_ff) == 4'h0 && $past(sel_ff, 2) == 4'h0 |-> !timer_tick_out)
    else $error("tick while stopped");
  a_div1_sync: assert property (
    $past(sel_ff) == 4'h1 && $past(sel_ff, 2) == 4'h1 && !$past(async_mode_out)
    && !$past(async_mode_out, 2) |-> timer_tick_out) else $error("undivided tick missing");
  a_async_gap: assert property (
    $past(async_mode_out) && $past(async_mode_out, 2) && !$past(fast_tick_in)
    |-> !timer_tick_out) else $error("tick without fast tick");
endmodule
bind tcp_top tcp_top_asserts chk_i (.*);

// File: tb/test_timer1_clock_prescaler.sv
`timescale 1ns/10ps
module test_timer1_clock_prescaler;
  import tcp_pkg::*;
  localparam logic [7:0] PCS = TCP_OFS_PLL_CONTROL_STATUS;
  localparam logic [7:0] TCB = TCP_OFS_TIMER_CONTROL_B;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ftick = 1'b0;
  logic lock = 1'b0;
  logic fuse = 1'b0;
  logic [7:0] rdat;
  logic tick;
  logic [7:0] rnd = 8'h58;
  int failures = 0;
  int checked = 0;
  tcp_top uut (.ref_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wr_data_in(wdat),
    .wr_en_in(wr), .rd_en_in(rd), .fast_tick_in(ftick), .pll_locked_in(lock),
    .fuse_pll_mode_in(fuse), .rd_data_out(rdat), .timer_tick_out(tick), .pll_on_out(),
    .async_mode_out(), .half_speed_out(), .divider_restart_out());
  // 125 MHz clock and a fast tick every second cycle
  initial forever #4 clk = ~clk;
  // Fast ticks run below the system rate here, so the sync margin is not exercised
  always @(posedge clk) ftick <= ~ftick;
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Ticks in 64 cycles for a given code and source ticks per 64 cycles
  function automatic logic [7:0] exp_ticks(input int k, input int src);
    return (k == 0) ? 8'h00 : 8'(src >> (k - 1));
  endfunction
  // Cycles from the restart write to the first tick in sync mode
  function automatic logic [7:0] exp_first(input int k);
    return (k == 0) ? 8'h00 : (k == 1) ? 8'h01 : 8'(1 + (1 << (k - 1)));
  endfunction
  task automatic chk(input string s, input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("read", rdat, e);
  endtask
  // Counts timer ticks over 64 cycles once the restart has settled
  // First tick position is checked unless f is FF
  task automatic cnt(input logic [7:0] e, input logic [7:0] f);
    logic [7:0] n;
    logic [7:0] first;
    n = 8'h00;
    first = 8'h00;
    for (int i = 1; i <= 68; i++) begin
      @(posedge clk);
      #1;
      if (i > 4) begin
        n = n + 8'(tick);
      end
      if (tick === 1'b1 && first == 8'h00) begin
        first = 8'(i);
      end
    end
    chk("ticks", n, e);
    if (f != 8'hFF) begin
      chk("first tick", first, f);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    rd_reg(TCB, 8'h00);
    rd_reg(PCS, 8'h00);
    wr_reg(PCS, 8'hFC);
    rd_reg(PCS, 8'h80);
    wr_reg(PCS, 8'h00);
    fuse <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg(PCS, 8'h02);
    // The fuses alone let the async bit take a one
    wr_reg(PCS, 8'h04);
    rd_reg(PCS, 8'h06);
    fuse <= 1'b0;
    repeat (4) @(posedge clk);
    rd_reg(PCS, 8'h04);
    wr_reg(PCS, 8'h00);
    // Random control values, then a read of an unmapped place
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      wr_reg(TCB, rnd);
      rd_reg(TCB, rnd & 8'hBF);
      rd_reg({2'b01, rnd[5:0]}, 8'h00);
    end
    for (int k = 0; k < 8; k++) begin
      wr_reg(TCB, 8'h40 | 8'(k));
      cnt(exp_ticks(k, 64), exp_first(k));
    end
    // Enter async mode: PLL on, settle time, lock poll, then async select
    wr_reg(TCB, 8'h00);
    wr_reg(PCS, 8'h02);
    rd_reg(PCS, 8'h02);
    lock <= 1'b1;
    repeat (TCP_LOCK_SETTLE_CYC) @(posedge clk);
    rd_reg(PCS, 8'h03);
    wr_reg(PCS, 8'h06);
    rd_reg(PCS, 8'h07);
    // Timer stopped before each change of the half-speed bit
    for (int h = 0; h < 2; h++) begin
      wr_reg(TCB, 8'h00);
      wr_reg(PCS, {h[0], 7'h06});
      for (int k = 1; k < 4; k++) begin
        wr_reg(TCB, 8'h40 | 8'(k));
        cnt(exp_ticks(k, 32 >> h), 8'hFF);
      end
    end
    end_of_test();
  end
endmodule
